// File: rtl/rce_read_cycle_ctrl.sv
// Notes on behaviour
// - policy codes 0..4, resets to timeout
// - duration 1..65535 tens of ms, reset 100
// - timeout ends cycle, reports data or no-read
// - continuous one-output: timeout restarts the cycle
// - edge/serial modes: timeout closes and reports
// - level: fall or timeout ends, rise restarts
// - new trigger is rising edge, serial trigger or start char, restarts
// - edge/serial trigger ends and begins cycles
// - level new-trigger: fall ends, rise reopens
// - timeout-or-trigger: first of either ends
// - last frame only in rapid capture
// - last-frame-or-trigger: first of either ends
// - continuous reads stay always in cycle
// - capture mode 0 rapid, 1 continuous
// - rapid captures spaced by programmable gap
// - level: start char opens, stop char closes
`timescale 1ns/10ps
`default_nettype none
module rce_read_cycle_ctrl #(
  parameter int TickCycles = rce_pkg::TICK_CYCLES
) (
  input wire logic sys_clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic extTrigPin, // external trigger pin
  input wire logic serialTrig, // serial trigger pulse
  input wire logic startChar, // serial start char pulse
  input wire logic stopChar, // serial stop char pulse
  input wire logic lastFrame, // last frame of capture
  input wire logic captureReady, // capture engine idle
  input wire logic decodeValid, // decode success pulse
  output logic cycleActive, // inside a read cycle
  output logic captureStrobe, // capture request pulse
  output logic sendData, // send decoded data pulse
  output logic sendNoRead, // send no-read pulse
  output logic irq // interrupt level
);

  rce_pkg::rce_ctrl_t ctrl;
  logic [rce_pkg::DUR_W-1:0] duration;
  logic [rce_pkg::GAP_W-1:0] gap;
  rce_pkg::rce_evt_t intStat;
  rce_pkg::rce_evt_t intEn;
  rce_pkg::rce_state_t state;
  rce_pkg::rce_state_t next_state;
  logic [rce_pkg::DUR_W-1:0] elapsed;
  logic [31:0] tickCnt;
  logic [rce_pkg::GAP_W-1:0] gapCnt;
  logic decoded;
  logic [2:0] trigSync;
  logic trigLevel;
  logic trigPrev;
  logic awHeld;
  logic wHeld;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic doWrite;
  logic tick;
  logic rise;
  logic fall;
  logic newTrig;
  logic levelMode;
  logic contMode;
  logic edgeMode;
  logic useTimeout;
  logic useTrig;
  logic useLast;
  logic timeoutEvt;
  logic endEvt;
  logic startEvt;
  logic restart;
  logic openCycle;
  logic closeCycle;
  rce_pkg::rce_evt_t evt;

  // write side: address and data are latched independently
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  // write response, error on an unmapped address
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rce_pkg::RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      if (awAddr == rce_pkg::ADDR_CTRL || awAddr == rce_pkg::ADDR_DUR ||
          awAddr == rce_pkg::ADDR_GAP || awAddr == rce_pkg::ADDR_ICLR ||
          awAddr == rce_pkg::ADDR_IEN) begin
        s_axi_bresp <= rce_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp <= rce_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // configuration registers; illegal codes leave the old value
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= rce_pkg::CTRL_RST;
      duration <= rce_pkg::DUR_RST;
      gap <= rce_pkg::GAP_RST;
      intEn <= '0;
    end else if (doWrite) begin
      if (awAddr == rce_pkg::ADDR_CTRL) begin
        if (wStrb[0] && wData[2:0] <= 3'(rce_pkg::POL_LAST_TRG) &&
            wData[7:5] <= 3'(rce_pkg::TRG_SER_EDGE)) begin
          ctrl <= rce_pkg::rce_ctrl_t'(wData[rce_pkg::CTRL_W-1:0]);
        end
      end else if (awAddr == rce_pkg::ADDR_DUR) begin
        // zero is outside the legal range, so it is dropped
        if (wStrb[1:0] == 2'h3 && wData[15:0] >= rce_pkg::DUR_MIN) begin
          duration <= wData[rce_pkg::DUR_W-1:0];
        end
      end else if (awAddr == rce_pkg::ADDR_GAP) begin
        if (wStrb[1:0] == 2'h3) begin
          gap <= wData[rce_pkg::GAP_W-1:0];
        end
      end else if (awAddr == rce_pkg::ADDR_IEN) begin
        if (wStrb[0]) begin
          intEn <= rce_pkg::rce_evt_t'(wData[rce_pkg::EVT_W-1:0]);
        end
      end
    end
  end

  // read channel, one cycle latency
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= rce_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= rce_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      if (s_axi_araddr == rce_pkg::ADDR_CTRL) begin
        s_axi_rdata[rce_pkg::CTRL_W-1:0] <= ctrl;
      end else if (s_axi_araddr == rce_pkg::ADDR_DUR) begin
        s_axi_rdata[rce_pkg::DUR_W-1:0] <= duration;
      end else if (s_axi_araddr == rce_pkg::ADDR_GAP) begin
        s_axi_rdata[rce_pkg::GAP_W-1:0] <= gap;
      end else if (s_axi_araddr == rce_pkg::ADDR_STAT) begin
        s_axi_rdata[rce_pkg::DUR_W-1:0] <= elapsed;
        s_axi_rdata[rce_pkg::STAT_ACTIVE] <= (state == rce_pkg::ST_ACTIVE);
        s_axi_rdata[rce_pkg::STAT_DECODED] <= decoded;
        s_axi_rdata[rce_pkg::STAT_TRIG] <= trigLevel;
      end else if (s_axi_araddr == rce_pkg::ADDR_ISTAT) begin
        s_axi_rdata[rce_pkg::EVT_W-1:0] <= intStat;
      end else if (s_axi_araddr == rce_pkg::ADDR_IEN) begin
        s_axi_rdata[rce_pkg::EVT_W-1:0] <= intEn;
      end else if (s_axi_araddr == rce_pkg::ADDR_ICLR) begin
        s_axi_rdata <= 32'h0000_0000; // write-only, reads zero
      end else begin
        s_axi_rresp <= rce_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // trigger pin sync; level moves only when stages 2 and 3 agree
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      trigSync <= 3'h0;
      trigLevel <= 1'b0;
      trigPrev <= 1'b0;
    end else begin
      trigSync <= {trigSync[1:0], extTrigPin};
      if (trigSync[1] == trigSync[2]) begin
        trigLevel <= trigSync[2];
      end
      trigPrev <= trigLevel;
    end
  end

  assign rise = trigLevel && !trigPrev;
  assign fall = !trigLevel && trigPrev;

  // mode decode
  assign levelMode = (ctrl.trigMode == rce_pkg::TRG_LEVEL);
  assign contMode = (ctrl.trigMode == rce_pkg::TRG_CONT) ||
                    (ctrl.trigMode == rce_pkg::TRG_CONT_ONE);
  assign edgeMode = !levelMode && !contMode;
  // only a rising edge, a serial trigger or a start char counts as new
  assign newTrig = ((ctrl.trigMode == rce_pkg::TRG_EDGE ||
                     ctrl.trigMode == rce_pkg::TRG_SER_EDGE) && rise) ||
                   ((ctrl.trigMode == rce_pkg::TRG_SERIAL ||
                     ctrl.trigMode == rce_pkg::TRG_SER_EDGE) &&
                    (serialTrig || startChar));
  assign useTimeout = (ctrl.policy == rce_pkg::POL_TIMEOUT) ||
                      (ctrl.policy == rce_pkg::POL_TO_TRIG);
  assign useTrig = (ctrl.policy == rce_pkg::POL_NEWTRIG) ||
                   (ctrl.policy == rce_pkg::POL_TO_TRIG) ||
                   (ctrl.policy == rce_pkg::POL_LAST_TRG);
  // last frame has no meaning without a finite capture sequence
  assign useLast = ((ctrl.policy == rce_pkg::POL_LAST) ||
                    (ctrl.policy == rce_pkg::POL_LAST_TRG)) &&
                   (ctrl.captureMode == rce_pkg::CAP_RAPID);

  // duration tick, phase reset at each cycle start
  assign tick = (tickCnt == 32'(TickCycles - 1));

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tickCnt <= 32'h0000_0000;
      elapsed <= 16'h0000;
    end else if (startEvt || state == rce_pkg::ST_IDLE) begin
      tickCnt <= 32'h0000_0000;
      elapsed <= 16'h0000;
    end else if (tick) begin
      tickCnt <= 32'h0000_0000;
      elapsed <= elapsed + 16'h0001;
    end else begin
      tickCnt <= tickCnt + 32'h0000_0001;
    end
  end

  assign timeoutEvt = (state == rce_pkg::ST_ACTIVE) && tick &&
                      (elapsed >= duration - 16'h0001);

  // level mode: pin or start/stop characters bound the cycle
  assign openCycle = rise || startChar;
  assign closeCycle = fall || stopChar;

  // end and start conditions
  always_comb begin
    endEvt = 1'b0;
    restart = 1'b0;
    startEvt = 1'b0;
    next_state = state;
    case (state)
      rce_pkg::ST_IDLE: begin
        if (contMode) begin
          startEvt = 1'b1;
        end else if (levelMode) begin
          startEvt = openCycle;
        end else begin
          startEvt = newTrig;
        end
        if (startEvt) begin
          next_state = rce_pkg::ST_ACTIVE;
        end
      end
      rce_pkg::ST_ACTIVE: begin
        if (levelMode) begin
          endEvt = closeCycle || (useTimeout && timeoutEvt) ||
                   (useLast && lastFrame);
        end else if (edgeMode) begin
          endEvt = (useTimeout && timeoutEvt) ||
                   (useTrig && newTrig) ||
                   (useLast && lastFrame);
          restart = useTrig && newTrig;
        end else begin
          endEvt = (useTimeout && timeoutEvt) ||
                   (useLast && lastFrame);
          restart = 1'b1;
        end
        startEvt = endEvt && restart;
        if (endEvt && !restart) begin
          next_state = rce_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = rce_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= rce_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign cycleActive = (state == rce_pkg::ST_ACTIVE);

  // decode tracking and host reporting
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      decoded <= 1'b0;
      sendData <= 1'b0;
      sendNoRead <= 1'b0;
    end else begin
      sendData <= 1'b0;
      sendNoRead <= 1'b0;
      if (endEvt) begin
        decoded <= 1'b0;
        if (ctrl.outAtEnd && (decoded || decodeValid)) begin
          sendData <= 1'b1;
        end else if (!decoded && !decodeValid) begin
          sendNoRead <= 1'b1;
        end
      end else if (cycleActive && decodeValid && !decoded) begin
        // a decode never closes a level cycle by itself
        decoded <= 1'b1;
        if (!ctrl.outAtEnd) begin
          sendData <= 1'b1;
        end
      end
    end
  end

  // capture requests: spaced in rapid mode, as ready in continuous
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gapCnt <= 16'h0000;
      captureStrobe <= 1'b0;
    end else begin
      captureStrobe <= 1'b0;
      if (startEvt) begin
        gapCnt <= 16'h0000;
        captureStrobe <= 1'b1;
      end else if (!cycleActive || endEvt) begin
        gapCnt <= 16'h0000;
      end else if (ctrl.captureMode == rce_pkg::CAP_RAPID) begin
        if (gapCnt >= gap) begin
          gapCnt <= 16'h0000;
          captureStrobe <= 1'b1;
        end else begin
          gapCnt <= gapCnt + 16'h0001;
        end
      end else begin
        captureStrobe <= captureReady && !captureStrobe;
      end
    end
  end

  // interrupt events; a set in the clearing cycle wins
  assign evt = '{noRead: endEvt && !decoded && !decodeValid,
                 timeout: timeoutEvt,
                 cycleEnd: endEvt,
                 cycleStart: startEvt};

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      intStat <= '0;
    end else if (doWrite && awAddr == rce_pkg::ADDR_ICLR && wStrb[0]) begin
      intStat <= (intStat &
                  ~rce_pkg::rce_evt_t'(wData[rce_pkg::EVT_W-1:0])) | evt;
    end else begin
      intStat <= intStat | evt;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(intStat & intEn);
    end
  end

endmodule
`default_nettype wire

// File: rtl/rce_pkg.sv
package rce_pkg;

  // end-of-cycle policy codes
  typedef enum logic [2:0] {
    POL_TIMEOUT  = 3'h0,
    POL_NEWTRIG  = 3'h1,
    POL_TO_TRIG  = 3'h2,
    POL_LAST     = 3'h3,
    POL_LAST_TRG = 3'h4
  } rce_policy_t;

  // read (trigger) modes
  typedef enum logic [2:0] {
    TRG_CONT     = 3'h0,
    TRG_CONT_ONE = 3'h1,
    TRG_LEVEL    = 3'h2,
    TRG_EDGE     = 3'h3,
    TRG_SERIAL   = 3'h4,
    TRG_SER_EDGE = 3'h5
  } rce_trig_t;

  // capture modes
  typedef enum logic {
    CAP_RAPID = 1'b0,
    CAP_CONT  = 1'b1
  } rce_cap_t;

  typedef enum logic {
    ST_IDLE   = 1'b0,
    ST_ACTIVE = 1'b1
  } rce_state_t;

  // control register layout, low byte of the word
  typedef struct packed {
    rce_trig_t trigMode;
    logic outAtEnd;
    rce_cap_t captureMode;
    rce_policy_t policy;
  } rce_ctrl_t;

  // event bits shared by the interrupt registers
  typedef struct packed {
    logic noRead;
    logic timeout;
    logic cycleEnd;
    logic cycleStart;
  } rce_evt_t;

  localparam int CTRL_W = 8;
  localparam int EVT_W = 4;
  localparam int DUR_W = 16;
  localparam int GAP_W = 16;

  localparam rce_ctrl_t CTRL_RST = '{TRG_EDGE, 1'b1, CAP_CONT, POL_TIMEOUT};
  localparam logic [DUR_W-1:0] DUR_RST = 16'h0064;
  localparam logic [DUR_W-1:0] DUR_MIN = 16'h0001;
  localparam logic [GAP_W-1:0] GAP_RST = 16'h0064;

  // byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DUR = 8'h04;
  localparam logic [7:0] ADDR_GAP = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_ISTAT = 8'h10;
  localparam logic [7:0] ADDR_ICLR = 8'h14;
  localparam logic [7:0] ADDR_IEN = 8'h18;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // status word positions
  localparam int STAT_ACTIVE = 16;
  localparam int STAT_DECODED = 17;
  localparam int STAT_TRIG = 18;

  // duration tick: 10 ms at a 10 ns clock
  localparam int TICK_MS = 10;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;

endpackage

// File: tb/rce_capture_model.sv
`timescale 1ns/10ps
`default_nettype none
module rce_capture_model (
  input wire logic sys_clk, // clock
  input wire logic rstn, // reset, active low
  input wire logic cycleActive, // controller in a read cycle
  input wire logic captureStrobe, // capture request
  input wire logic [3:0] numFrames, // captures in one sequence
  input wire logic decodeOn, // every capture decodes
  output logic captureReady, // engine idle
  output logic lastFrame, // final frame done
  output logic decodeValid // decode success
);
  logic [3:0] count;
  logic [1:0] busy;

  // ready drops at once so a strobe is never doubled
  assign captureReady = (busy == 2'h0) && !captureStrobe;

  // two cycles of integration and transfer per capture
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      count <= 4'h0;
      busy <= 2'h0;
      lastFrame <= 1'b0;
      decodeValid <= 1'b0;
    end else begin
      lastFrame <= 1'b0;
      decodeValid <= 1'b0;
      if (busy != 2'h0)
        busy <= busy - 2'h1;
      if (!cycleActive)
        count <= 4'h0;
      if (captureStrobe) begin
        busy <= 2'h2;
        count <= count + 4'h1;
        lastFrame <= (count + 4'h1) == numFrames;
        decodeValid <= decodeOn;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/rce_read_cycle_ctrl_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module rce_rcc_checker (
  input wire logic sys_clk, // clock
  input wire logic rstn, // reset, active low
  input wire logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  input wire logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic cycleActive, // in a read cycle
  input wire logic sendData, // data report
  input wire logic sendNoRead // no-read report
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // register access answers and holds
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write not answered");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");

  // reports to the host
  a_one_report: assert property (!(sendData && sendNoRead))
    else $error("data and no-read together");
  a_noread_pulse: assert property (sendNoRead |=> !sendNoRead)
    else $error("no-read longer than a cycle");
  a_data_pulse: assert property (sendData |=> !sendData)
    else $error("data report longer than a cycle");
  a_end_reports: assert property (
    $fell(cycleActive) |-> ##[0:1] (sendData || sendNoRead))
    else $error("cycle closed without a report");
endmodule
`default_nettype wire

bind rce_read_cycle_ctrl rce_rcc_checker i_rce_rcc_checker (.sys_clk, .rstn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .cycleActive, .sendData, .sendNoRead);

// File: tb/rce_read_cycle_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module rce_read_cycle_ctrl_tb;
  localparam int TICK = 10;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdVal;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, lastFrame, captureReady, decodeValid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic extTrigPin = 1'b0, decodeOn = 1'b0;
  logic [2:0] pulses = 3'h0;
  logic [3:0] numFrames = 4'h3;
  logic cycleActive, captureStrobe, sendData, sendNoRead, irq;
  wire logic serialTrig = pulses[0];
  wire logic startChar = pulses[1];
  wire logic stopChar = pulses[2];
  int fail_count = 0, num_checks = 0, cyc = 0, k, n;
  int nData = 0, nNoRead = 0, nFall = 0, nStrobe = 0, strobeAt = 0, gap = 0;

  always #5 sys_clk = ~sys_clk;

  rce_read_cycle_ctrl #(.TickCycles(TICK)) i_rce_read_cycle_ctrl (
    .sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .extTrigPin, .serialTrig, .startChar, .stopChar, .lastFrame,
    .captureReady, .decodeValid, .cycleActive, .captureStrobe, .sendData,
    .sendNoRead, .irq);

  rce_capture_model i_rce_capture_model (.sys_clk, .rstn, .cycleActive,
    .captureStrobe, .numFrames, .decodeOn, .captureReady, .lastFrame,
    .decodeValid);

  // event tallies; the ceiling cuts a hang short
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (sendData === 1'b1) nData <= nData + 1;
    if (sendNoRead === 1'b1) nNoRead <= nNoRead + 1;
    if ($fell(cycleActive)) nFall <= nFall + 1;
    if (captureStrobe === 1'b1) begin
      gap <= cyc - strobeAt;
      strobeAt <= cyc;
      nStrobe <= nStrobe + 1;
    end
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish;
    end
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic axi_read(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdVal = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  // output at end of cycle is kept on throughout
  task automatic cfg(input logic [2:0] t, input logic c, input logic [2:0] p);
    axi_write(rce_pkg::ADDR_CTRL, {24'h0, t, 1'b1, c, p});
  endtask

  task automatic pulse(input logic [2:0] p);
    pulses <= p;
    @(posedge sys_clk);
    pulses <= 3'h0;
    repeat (2) @(posedge sys_clk);
  endtask

  // bounded wait for the cycle flag, n counts cycles
  task automatic wait_act(input logic v);
    n = 0;
    while (cycleActive !== v && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    // defaults, refused values, unmapped place
    axi_read(rce_pkg::ADDR_CTRL);
    check(rdVal, 32'h0000_0078);
    axi_write(rce_pkg::ADDR_DUR, 32'h0);
    axi_write(rce_pkg::ADDR_CTRL, 32'h0000_007D);
    axi_read(rce_pkg::ADDR_CTRL);
    check(rdVal, 32'h0000_0078);
    axi_read(rce_pkg::ADDR_DUR);
    check(rdVal, 32'h0000_0064);
    axi_write(rce_pkg::ADDR_DUR, 32'h0000_FFFF);
    axi_read(rce_pkg::ADDR_DUR);
    check(rdVal, 32'h0000_FFFF);
    axi_read(8'h1C);
    check(resp, rce_pkg::RESP_SLVERR);
    for (int p = 0; p < 5; p++) begin
      cfg(3'h3, p[0], p[2:0]);
      axi_read(rce_pkg::ADDR_CTRL);
      check(rdVal, {24'h0, 3'h3, 1'b1, p[0], p[2:0]});
    end
    axi_write(rce_pkg::ADDR_DUR, 32'h3);
    axi_write(rce_pkg::ADDR_GAP, 32'h4);
    axi_write(rce_pkg::ADDR_IEN, 32'hF);
    axi_write(rce_pkg::ADDR_ICLR, 32'hF);
    // timeout closes a serial cycle with a no-read, raising the interrupt
    cfg(rce_pkg::TRG_SERIAL, rce_pkg::CAP_CONT, rce_pkg::POL_TIMEOUT);
    k = nNoRead;
    pulse(3'h1);
    wait_act(1'b1);
    wait_act(1'b0);
    check(n > 27 && n < 32, 1);
    repeat (2) @(posedge sys_clk);
    check(nNoRead - k, 1);
    axi_read(rce_pkg::ADDR_ISTAT);
    check(rdVal, 32'hF);
    check(irq, 1'b1);
    axi_write(rce_pkg::ADDR_ICLR, 32'hF);
    axi_read(rce_pkg::ADDR_ISTAT);
    check({rdVal, irq}, 33'h0);
    // a decode is reported as data at the end
    decodeOn <= 1'b1;
    k = nData;
    pulse(3'h1);
    wait_act(1'b1);
    wait_act(1'b0);
    repeat (2) @(posedge sys_clk);
    check(nData - k, 1);
    // one-output continuous: timeout reopens, same symbol again
    k = nData;
    n = nFall;
    cfg(rce_pkg::TRG_CONT_ONE, rce_pkg::CAP_CONT, rce_pkg::POL_TIMEOUT);
    repeat (65) @(posedge sys_clk);
    check(nData - k, 2);
    check({cycleActive, nFall - n}, {1'b1, 32'h0});
    cfg(rce_pkg::TRG_SER_EDGE, rce_pkg::CAP_CONT, rce_pkg::POL_NEWTRIG);
    decodeOn <= 1'b0;
    wait_act(1'b0);
    // new trigger: rising pin restarts, duration ignored
    pulse(3'h1);
    repeat (40) @(posedge sys_clk);
    check(cycleActive, 1'b1);
    k = nNoRead;
    extTrigPin <= 1'b1;
    repeat (10) @(posedge sys_clk);
    extTrigPin <= 1'b0;
    repeat (10) @(posedge sys_clk);
    check({cycleActive, nNoRead - k}, {1'b1, 32'h1});
    // timeout or trigger: restart also restarts the duration
    cfg(rce_pkg::TRG_SERIAL, rce_pkg::CAP_CONT, rce_pkg::POL_TO_TRIG);
    wait_act(1'b0);
    pulse(3'h1);
    repeat (15) @(posedge sys_clk);
    k = nNoRead;
    pulse(3'h1);
    wait_act(1'b0);
    check({nNoRead - k > 0, n > 24 && n < 32}, 2'h3);
    // level trigger: fall ends, timeout ends, rise needed again
    axi_write(rce_pkg::ADDR_IEN, 32'h0);
    cfg(rce_pkg::TRG_LEVEL, rce_pkg::CAP_CONT, rce_pkg::POL_TIMEOUT);
    extTrigPin <= 1'b1;
    wait_act(1'b1);
    repeat (5) @(posedge sys_clk);
    extTrigPin <= 1'b0;
    wait_act(1'b0);
    check(n < 10, 1);
    extTrigPin <= 1'b1;
    wait_act(1'b1);
    wait_act(1'b0);
    repeat (20) @(posedge sys_clk);
    check({n > 26 && n < 32, cycleActive}, 2'h2);
    extTrigPin <= 1'b0;
    cfg(rce_pkg::TRG_LEVEL, rce_pkg::CAP_CONT, rce_pkg::POL_NEWTRIG);
    extTrigPin <= 1'b1;
    wait_act(1'b1);
    repeat (40) @(posedge sys_clk);
    extTrigPin <= 1'b0;
    wait_act(1'b0);
    repeat (10) @(posedge sys_clk);
    check({n < 10, cycleActive}, 2'h2);
    // start character opens, decodes keep it open, stop closes
    decodeOn <= 1'b1;
    pulse(3'h2);
    wait_act(1'b1);
    repeat (15) @(posedge sys_clk);
    check(cycleActive, 1'b1);
    pulse(3'h4);
    wait_act(1'b0);
    check(n < 5, 1);
    decodeOn <= 1'b0;
    // rapid capture ends on the last frame, strobes spaced gap+1
    cfg(rce_pkg::TRG_SERIAL, rce_pkg::CAP_RAPID, rce_pkg::POL_LAST);
    k = nStrobe;
    pulse(3'h1);
    wait_act(1'b1);
    wait_act(1'b0);
    check({n < 25, nStrobe - k}, {1'b1, 32'h3});
    check(gap, 5);
    // last frame means nothing in continuous capture
    cfg(rce_pkg::TRG_SERIAL, rce_pkg::CAP_CONT, rce_pkg::POL_LAST);
    pulse(3'h1);
    repeat (40) @(posedge sys_clk);
    check(cycleActive, 1'b1);
    cfg(rce_pkg::TRG_SERIAL, rce_pkg::CAP_CONT, rce_pkg::POL_TIMEOUT);
    wait_act(1'b0);
    // last frame or trigger: trigger restarts, then last frame ends
    axi_write(rce_pkg::ADDR_GAP, 32'h14);
    cfg(rce_pkg::TRG_SERIAL, rce_pkg::CAP_RAPID, rce_pkg::POL_LAST_TRG);
    pulse(3'h1);
    repeat (8) @(posedge sys_clk);
    k = nNoRead;
    pulse(3'h1);
    check({cycleActive, nNoRead - k}, {1'b1, 32'h1});
    wait_act(1'b0);
    check(n < 100, 1);
    // events pile up but the masked interrupt stays low
    axi_read(rce_pkg::ADDR_ISTAT);
    check({rdVal != 0, irq}, 2'h2);
    tally_and_finish;
  end
endmodule
`default_nettype wire
